// file: core/psw_pkg.sv
// Package of constants and types shared by the processor-state immediate writer.
package psw_pkg;

	localparam int          PSW_SEL_W      = 3;
	localparam int          PSW_IMM_W      = 4;
	localparam logic [5:0]  PSW_SYN_TRAP   = 6'h18;
	localparam logic [1:0]  PSW_EL0        = 2'h0;
	localparam logic [1:0]  PSW_EL1        = 2'h1;
	localparam logic [1:0]  PSW_EL2        = 2'h2;
	localparam logic [1:0]  PSW_EL3        = 2'h3;

	// Field selector encodings as {field_sel_hi, field_sel_lo}.
	localparam logic [5:0]  PSW_SEL_UAO    = 6'h03;
	localparam logic [5:0]  PSW_SEL_PAN    = 6'h04;
	localparam logic [5:0]  PSW_SEL_STACK_POINTER_SELECT  = 6'h05;
	localparam logic [5:0]  PSW_SEL_AINT   = 6'h08;
	localparam logic [5:0]  PSW_SEL_SSB    = 6'h19;
	localparam logic [5:0]  PSW_SEL_DIT    = 6'h1a;
	localparam logic [5:0]  PSW_SEL_SMCTL  = 6'h1b;
	localparam logic [5:0]  PSW_SEL_TCO    = 6'h1c;
	localparam logic [5:0]  PSW_SEL_MSET   = 6'h1e;
	localparam logic [5:0]  PSW_SEL_MCLR   = 6'h1f;
	localparam logic [2:0]  PSW_ALIAS_HI   = 3'h3;
	localparam logic [2:0]  PSW_ALIAS_LO   = 3'h3;

	// Streaming alias target in immediate_field bits 2:1.
	localparam logic [1:0]  PSW_TGT_SM     = 2'h1;
	localparam logic [1:0]  PSW_TGT_ZA     = 2'h2;
	localparam logic [1:0]  PSW_TGT_BOTH   = 2'h3;

	// Reset values of processor state.
	localparam logic [3:0]  PSW_RST_MASK   = 4'hf;
	localparam logic        PSW_RST_SP     = 1'b1;
	localparam logic        PSW_RST_FLAG   = 1'b0;

	typedef enum logic [3:0] {
		PSW_F_NONE,
		PSW_F_UAO,
		PSW_F_PAN,
		PSW_F_SP,
		PSW_F_AINT,
		PSW_F_SSB,
		PSW_F_DIT,
		PSW_F_SM,
		PSW_F_ZA,
		PSW_F_SMZA,
		PSW_F_TCO,
		PSW_F_MSET,
		PSW_F_MCLR
	} psw_field_e;

	typedef enum logic [1:0] {
		PSW_DIS_PLAIN,
		PSW_DIS_START,
		PSW_DIS_STOP
	} psw_disasm_e;

endpackage

// file: core/psw_dec_if.sv
// Interface carrying the decoded field selection between decoder and core.
`timescale 1ns/1ps
interface psw_dec_if;
	import psw_pkg::*;
	logic [PSW_SEL_W-1:0] sel_hi;
	logic [PSW_SEL_W-1:0] sel_lo;
	logic [PSW_IMM_W-1:0] imm;
	psw_field_e           field;
	logic                 undef;
	psw_disasm_e          disasm;

	modport dec (input sel_hi, input sel_lo, input imm, output field, output undef, output disasm);
	modport use_side (output sel_hi, output sel_lo, output imm, input field, input undef,
		input disasm);
endinterface

// file: core/psw_decoder.sv
// Combinational decode of field selectors into a processor-state field.
`timescale 1ns/1ps
module psw_decoder
	import psw_pkg::*;
#(
	parameter bit HAS_UAO  = 1'b1,
	parameter bit HAS_PAN  = 1'b1,
	parameter bit HAS_AINT = 1'b1,
	parameter bit HAS_SSB  = 1'b1,
	parameter bit HAS_DIT  = 1'b1,
	parameter bit HAS_MAT  = 1'b1,
	parameter bit HAS_TCO  = 1'b1
) (
	psw_dec_if.dec d
);
	import psw_pkg::*;

	always_comb begin
		d.field = PSW_F_NONE;
		case ({d.sel_hi, d.sel_lo})
			PSW_SEL_UAO:   d.field = HAS_UAO ? PSW_F_UAO : PSW_F_NONE;
			PSW_SEL_PAN:   d.field = HAS_PAN ? PSW_F_PAN : PSW_F_NONE;
			PSW_SEL_STACK_POINTER_SELECT: d.field = PSW_F_SP;
			PSW_SEL_AINT: begin
				if (d.imm[3:1] == 3'h0 && HAS_AINT) begin
					d.field = PSW_F_AINT;
				end
			end
			PSW_SEL_SSB:   d.field = HAS_SSB ? PSW_F_SSB : PSW_F_NONE;
			PSW_SEL_DIT:   d.field = HAS_DIT ? PSW_F_DIT : PSW_F_NONE;
			PSW_SEL_SMCTL: begin
				if (!d.imm[3] && HAS_MAT) begin
					case (d.imm[2:1])
						PSW_TGT_SM:   d.field = PSW_F_SM;
						PSW_TGT_ZA:   d.field = PSW_F_ZA;
						PSW_TGT_BOTH: d.field = PSW_F_SMZA;
						default:      d.field = PSW_F_NONE;
					endcase
				end
			end
			PSW_SEL_TCO:   d.field = HAS_TCO ? PSW_F_TCO : PSW_F_NONE;
			PSW_SEL_MSET:  d.field = PSW_F_MSET;
			PSW_SEL_MCLR:  d.field = PSW_F_MCLR;
			default:       d.field = PSW_F_NONE;
		endcase
	end

	// Reserved rows and absent features both land here.
	assign d.undef = (d.field == PSW_F_NONE);

	always_comb begin
		d.disasm = PSW_DIS_PLAIN;
		if (d.sel_hi == PSW_ALIAS_HI && d.sel_lo == PSW_ALIAS_LO && !d.imm[3]) begin
			d.disasm = d.imm[0] ? PSW_DIS_START : PSW_DIS_STOP;
		end
	end

endmodule

// file: core/psw_writer.sv
// Processor-state immediate writer: executes the move-immediate instruction.
`timescale 1ns/1ps
module psw_writer
	import psw_pkg::*;
#(
	parameter bit HAS_UAO  = 1'b1,
	parameter bit HAS_PAN  = 1'b1,
	parameter bit HAS_AINT = 1'b1,
	parameter bit HAS_SSB  = 1'b1,
	parameter bit HAS_DIT  = 1'b1,
	parameter bit HAS_MAT  = 1'b1,
	parameter bit HAS_TCO  = 1'b1
) (
	input  wire logic                          i_clock,
	input  wire logic                          i_nrst,
	input  wire logic                          i_valid,
	input  wire logic [psw_pkg::PSW_SEL_W-1:0] i_field_sel_hi,
	input  wire logic [psw_pkg::PSW_SEL_W-1:0] i_field_sel_lo,
	input  wire logic [psw_pkg::PSW_IMM_W-1:0] i_immediate_field,
	input  wire logic [1:0]                    i_exc_level,
	input  wire logic                          i_extended_hyp_config_en,
	input  wire logic                          i_interrupt_all_trap_bit,
	input  wire logic                          i_matrix_access_ok,
	output logic                               o_done,
	output logic                               o_undef,
	output logic                               o_trap,
	output logic [1:0]                         o_trap_level,
	output logic [5:0]                         o_trap_syndrome,
	output logic                               o_matrix_access_fault,
	output psw_pkg::psw_disasm_e               o_disasm,
	output logic [3:0]                         o_mask_dbg_err_irq_fiq,
	output logic                               o_store_bypass_safe_flag,
	output logic                               o_stack_pointer_select,
	output logic                               o_privileged_access_never,
	output logic                               o_user_access_override,
	output logic                               o_data_independent_timing,
	output logic                               o_tag_check_override,
	output logic                               o_interrupt_all_mask,
	output logic                               o_streaming_mode_ctl,
	output logic                               o_matrix_storage_ctl
);
	import psw_pkg::*;

	psw_dec_if dec ();

	logic [3:0] mask_ff;
	logic       ssb_ff;
	logic       sp_ff;
	logic       pan_ff;
	logic       uao_ff;
	logic       dit_ff;
	logic       tco_ff;
	logic       aint_ff;
	logic       sm_ff;
	logic       za_ff;
	logic       done_ff;
	logic       undef_ff;
	logic       trap_ff;
	logic       fault_ff;
	psw_disasm_e disasm_ff;

	logic       bit0;
	logic       exec;
	logic       aint_trap;
	logic       mat_sel;
	logic       mat_go;

	assign dec.sel_hi = i_field_sel_hi;
	assign dec.sel_lo = i_field_sel_lo;
	assign dec.imm    = i_immediate_field;

	psw_decoder #(
		.HAS_UAO  (HAS_UAO),
		.HAS_PAN  (HAS_PAN),
		.HAS_AINT (HAS_AINT),
		.HAS_SSB  (HAS_SSB),
		.HAS_DIT  (HAS_DIT),
		.HAS_MAT  (HAS_MAT),
		.HAS_TCO  (HAS_TCO)
	) u_dec (
		.d (dec)
	);

	// Single-bit fields only ever see bit 0; the upper bits are don't-care except where AINT and the streaming controls decode them.
	assign bit0 = i_immediate_field[0];
	assign exec = i_valid && !dec.undef;

	assign aint_trap = (dec.field == PSW_F_AINT) && bit0 && (i_exc_level == PSW_EL1)
		&& i_extended_hyp_config_en && i_interrupt_all_trap_bit;

	assign mat_sel = (dec.field == PSW_F_SM) || (dec.field == PSW_F_ZA)
		|| (dec.field == PSW_F_SMZA);
	// The access check gates every streaming control write before state moves.
	assign mat_go = exec && mat_sel && i_matrix_access_ok;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mask_ff <= PSW_RST_MASK;
		end else if (exec && dec.field == PSW_F_MSET) begin
			mask_ff <= mask_ff | i_immediate_field;
		end else if (exec && dec.field == PSW_F_MCLR) begin
			mask_ff <= mask_ff & ~i_immediate_field;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ssb_ff <= PSW_RST_FLAG;
			sp_ff  <= PSW_RST_SP;
			pan_ff <= PSW_RST_FLAG;
			uao_ff <= PSW_RST_FLAG;
			dit_ff <= PSW_RST_FLAG;
			tco_ff <= PSW_RST_FLAG;
		end else if (exec) begin
			case (dec.field)
				PSW_F_SSB: ssb_ff <= bit0;
				PSW_F_SP:  sp_ff  <= bit0;
				PSW_F_PAN: pan_ff <= bit0;
				PSW_F_UAO: uao_ff <= bit0;
				PSW_F_DIT: dit_ff <= bit0;
				PSW_F_TCO: tco_ff <= bit0;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			aint_ff <= PSW_RST_FLAG;
		end else if (exec && dec.field == PSW_F_AINT && !aint_trap) begin
			aint_ff <= bit0;
		end
	end

	// A clear bit 0 is the stop alias and clears the same targets start would set.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sm_ff <= PSW_RST_FLAG;
			za_ff <= PSW_RST_FLAG;
		end else if (mat_go) begin
			if (dec.field != PSW_F_ZA) begin
				sm_ff <= bit0;
			end
			if (dec.field != PSW_F_SM) begin
				za_ff <= bit0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			done_ff   <= 1'b0;
			undef_ff  <= 1'b0;
			trap_ff   <= 1'b0;
			fault_ff  <= 1'b0;
			disasm_ff <= PSW_DIS_PLAIN;
		end else begin
			done_ff   <= exec && !aint_trap && !(mat_sel && !i_matrix_access_ok);
			undef_ff  <= i_valid && dec.undef;
			trap_ff   <= exec && aint_trap;
			fault_ff  <= exec && mat_sel && !i_matrix_access_ok;
			disasm_ff <= i_valid ? dec.disasm : disasm_ff;
		end
	end

	assign o_done                    = done_ff;
	assign o_undef                   = undef_ff;
	assign o_trap                    = trap_ff;
	assign o_trap_level              = PSW_EL2;
	assign o_trap_syndrome           = PSW_SYN_TRAP;
	assign o_matrix_access_fault     = fault_ff;
	assign o_disasm                  = disasm_ff;
	assign o_mask_dbg_err_irq_fiq    = mask_ff;
	assign o_store_bypass_safe_flag  = ssb_ff;
	assign o_stack_pointer_select    = sp_ff;
	assign o_privileged_access_never = pan_ff;
	assign o_user_access_override    = uao_ff;
	assign o_data_independent_timing = dit_ff;
	assign o_tag_check_override      = tco_ff;
	assign o_interrupt_all_mask      = aint_ff;
	assign o_streaming_mode_ctl      = sm_ff;
	assign o_matrix_storage_ctl      = za_ff;

endmodule

// file: dv/psw_writer_monitor.sv
// Concurrent checks on the processor-state immediate writer ports.
`timescale 1ns/1ps
module psw_writer_monitor
	import psw_pkg::*;
(
	input wire logic                          i_clock,
	input wire logic                          i_nrst,
	input wire logic                          i_valid,
	input wire logic [psw_pkg::PSW_SEL_W-1:0] i_field_sel_hi,
	input wire logic [psw_pkg::PSW_SEL_W-1:0] i_field_sel_lo,
	input wire logic [psw_pkg::PSW_IMM_W-1:0] i_immediate_field,
	input wire logic [1:0]                    i_exc_level,
	input wire logic                          i_extended_hyp_config_en,
	input wire logic                          i_interrupt_all_trap_bit,
	input wire logic                          i_matrix_access_ok,
	input wire logic                          o_done,
	input wire logic                          o_undef,
	input wire logic                          o_trap,
	input wire logic [1:0]                    o_trap_level,
	input wire logic [5:0]                    o_trap_syndrome,
	input wire logic                          o_matrix_access_fault,
	input wire psw_pkg::psw_disasm_e          o_disasm,
	input wire logic [3:0]                    o_mask_dbg_err_irq_fiq,
	input wire logic                          o_privileged_access_never,
	input wire logic                          o_interrupt_all_mask,
	input wire logic                          o_streaming_mode_ctl,
	input wire logic                          o_matrix_storage_ctl
);
	// Level one only, so the lowest-level access limits never mask a check.
	wire       go  = i_valid && (i_exc_level == PSW_EL1);
	wire [5:0] sel = {i_field_sel_hi, i_field_sel_lo};
	wire       smc = go && (sel == PSW_SEL_SMCTL) && i_matrix_access_ok;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	AST_MASK_SET: assert property (go && sel == PSW_SEL_MSET |=>
		o_mask_dbg_err_irq_fiq == ($past(o_mask_dbg_err_irq_fiq) | $past(i_immediate_field)))
		else $error("mask set wrong");
	AST_MASK_CLR: assert property (go && sel == PSW_SEL_MCLR |=>
		o_mask_dbg_err_irq_fiq == ($past(o_mask_dbg_err_irq_fiq) & ~$past(i_immediate_field)))
		else $error("mask clear wrong");
	AST_FLAG_BIT0: assert property (go && sel == PSW_SEL_PAN |=>
		{3'h0, o_privileged_access_never} == ($past(i_immediate_field) & 4'h1))
		else $error("flag not loaded from bit 0");
	AST_AINT_WIDE: assert property (go && sel == PSW_SEL_AINT && i_immediate_field[3:1] != 3'h0
		|=> o_undef && $stable(o_interrupt_all_mask)) else $error("wide immediate accepted");
	AST_AINT_TRAP: assert property (go && sel == PSW_SEL_AINT && i_immediate_field == 4'h1
		&& i_extended_hyp_config_en && i_interrupt_all_trap_bit |=> o_trap
		&& o_trap_level == PSW_EL2 && o_trap_syndrome == PSW_SYN_TRAP
		&& $stable(o_interrupt_all_mask)) else $error("trap wrong");
	AST_START_BOTH: assert property (smc && i_immediate_field == 4'h7 |=>
		o_streaming_mode_ctl && o_matrix_storage_ctl && o_disasm == PSW_DIS_START)
		else $error("start both wrong");
	AST_START_MODE: assert property (smc && i_immediate_field == 4'h3 |=>
		o_streaming_mode_ctl && $stable(o_matrix_storage_ctl)) else $error("start mode wrong");
	AST_START_STOR: assert property (smc && i_immediate_field == 4'h5 |=>
		o_matrix_storage_ctl && $stable(o_streaming_mode_ctl)) else $error("start storage wrong");
	AST_STOP_BOTH: assert property (smc && i_immediate_field == 4'h6 |=>
		!o_streaming_mode_ctl && !o_matrix_storage_ctl && o_disasm == PSW_DIS_STOP)
		else $error("stop both wrong");
	AST_ACCESS: assert property (go && sel == PSW_SEL_SMCTL && !i_matrix_access_ok
		&& i_immediate_field[3] == 1'b0 && i_immediate_field[2:1] != 2'h0
		|=> o_matrix_access_fault && $stable(o_streaming_mode_ctl)
		&& $stable(o_matrix_storage_ctl)) else $error("access fault wrong");
	AST_RESERVED: assert property (go && (sel == 6'h18 || sel == 6'h1d) |=>
		o_undef && $stable(o_mask_dbg_err_irq_fiq)) else $error("reserved row accepted");
	AST_ONE_ANSWER: assert property (i_valid |=>
		$onehot({o_done, o_undef, o_trap, o_matrix_access_fault})) else $error("answer count wrong");

	cover property (o_trap);
	cover property (o_matrix_access_fault);
	cover property (smc && i_immediate_field == 4'h7);
endmodule

bind psw_writer psw_writer_monitor u_mon (.i_clock, .i_nrst, .i_valid, .i_field_sel_hi,
	.i_field_sel_lo, .i_immediate_field, .i_exc_level, .i_extended_hyp_config_en,
	.i_interrupt_all_trap_bit, .i_matrix_access_ok, .o_done, .o_undef, .o_trap, .o_trap_level,
	.o_trap_syndrome, .o_matrix_access_fault, .o_disasm, .o_mask_dbg_err_irq_fiq,
	.o_privileged_access_never, .o_interrupt_all_mask, .o_streaming_mode_ctl,
	.o_matrix_storage_ctl);

// file: dv/pstate_immediate_writer_tb_top.sv
// Self-checking bench for the processor-state immediate writer.
`timescale 1ns/1ps
module pstate_immediate_writer_tb_top;
	import psw_pkg::*;
	logic        i_clock = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_valid = 1'b0;
	logic [2:0]  i_field_sel_hi = 3'h0;
	logic [2:0]  i_field_sel_lo = 3'h0;
	logic [3:0]  i_immediate_field = 4'h0;
	logic [1:0]  i_exc_level = PSW_EL1;
	logic        hyp_en = 1'b0;
	logic        trap_bit = 1'b0;
	logic        access_ok = 1'b1;
	logic        done, undef, trap, fault, ssb, sp, privileged_access_never, user_access_override, data_independent_timing, tag_check_override, aint, sm, za;
	logic [1:0]  trap_lvl;
	logic [5:0]  trap_syn;
	psw_disasm_e disasm;
	logic [3:0]  mask;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	wire [18:0]  got = {done, undef, trap, fault, disasm, mask, ssb, sp, privileged_access_never, user_access_override, data_independent_timing, tag_check_override, aint,
		sm, za};
	// Row: selector, immediate, answer pulses, disassembly class, state after.
	logic [28:0] rows [22] = '{
		{6'h1f, 4'h5, 4'h8, 2'h0, 13'h1480}, {6'h1e, 4'h4, 4'h8, 2'h0, 13'h1c80},
		{6'h19, 4'h1, 4'h8, 2'h0, 13'h1d80}, {6'h05, 4'he, 4'h8, 2'h0, 13'h1d00},
		{6'h04, 4'h3, 4'h8, 2'h0, 13'h1d40}, {6'h03, 4'h9, 4'h8, 2'h0, 13'h1d60},
		{6'h1a, 4'hf, 4'h8, 2'h0, 13'h1d70}, {6'h1c, 4'h1, 4'h8, 2'h0, 13'h1d78},
		{6'h08, 4'h1, 4'h8, 2'h0, 13'h1d7c}, {6'h08, 4'h2, 4'h4, 2'h0, 13'h1d7c},
		{6'h1b, 4'h3, 4'h8, 2'h1, 13'h1d7e}, {6'h1b, 4'h5, 4'h8, 2'h1, 13'h1d7f},
		{6'h1b, 4'h2, 4'h8, 2'h2, 13'h1d7d}, {6'h1b, 4'h7, 4'h8, 2'h1, 13'h1d7f},
		{6'h1b, 4'h4, 4'h8, 2'h2, 13'h1d7e}, {6'h1b, 4'h6, 4'h8, 2'h2, 13'h1d7c},
		{6'h1b, 4'h1, 4'h4, 2'h1, 13'h1d7c}, {6'h1b, 4'h9, 4'h4, 2'h0, 13'h1d7c},
		{6'h18, 4'h0, 4'h4, 2'h0, 13'h1d7c}, {6'h1d, 4'h3, 4'h4, 2'h0, 13'h1d7c},
		{6'h1f, 4'hf, 4'h8, 2'h0, 13'h017c}, {6'h08, 4'h0, 4'h8, 2'h0, 13'h0178}
	};

	always #4 i_clock = ~i_clock;

	psw_writer u_dut (.i_clock, .i_nrst, .i_valid, .i_field_sel_hi, .i_field_sel_lo,
		.i_immediate_field, .i_exc_level, .i_extended_hyp_config_en(hyp_en),
		.i_interrupt_all_trap_bit(trap_bit), .i_matrix_access_ok(access_ok), .o_done(done),
		.o_undef(undef), .o_trap(trap), .o_trap_level(trap_lvl), .o_trap_syndrome(trap_syn),
		.o_matrix_access_fault(fault), .o_disasm(disasm), .o_mask_dbg_err_irq_fiq(mask),
		.o_store_bypass_safe_flag(ssb), .o_stack_pointer_select(sp),
		.o_privileged_access_never(privileged_access_never), .o_user_access_override(user_access_override),
		.o_data_independent_timing(data_independent_timing), .o_tag_check_override(tag_check_override),
		.o_interrupt_all_mask(aint), .o_streaming_mode_ctl(sm), .o_matrix_storage_ctl(za));

	task automatic report_and_stop();
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [3:0] p, input logic [1:0] d, input logic [12:0] s);
		checked++;
		if (got !== {p, d, s}) begin
			bad_count++;
			$display("unexpected at %0t ns: got %h want %h", $time, got, {p, d, s});
		end
	endtask

	// One isolated instruction; the control inputs ride with it.
	task automatic step(input logic [5:0] sl, input logic [3:0] im, input logic [2:0] ctl);
		@(posedge i_clock);
		{i_field_sel_hi, i_field_sel_lo} <= sl;
		i_immediate_field <= im;
		{hyp_en, trap_bit, access_ok} <= ctl;
		i_valid <= 1'b1;
		@(posedge i_clock);
		i_valid <= 1'b0;
		#1;
	endtask

	// A hang would otherwise stall the run forever.
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (16) @(posedge i_clock);
		#1;
		chk(4'h0, 2'h0, 13'h1e80);
		@(posedge i_clock);
		i_nrst <= 1'b1;
		// Rows go back to back, so each check lands while the next row is sampled.
		for (int i = 0; i <= 22; i++) begin
			@(posedge i_clock);
			{i_field_sel_hi, i_field_sel_lo, i_immediate_field} <= rows[i % 22][28:19];
			i_valid <= (i < 22);
			#1;
			if (i > 0) chk(rows[i-1][18:15], rows[i-1][14:13], rows[i-1][12:0]);
		end
		step(PSW_SEL_AINT, 4'h1, 3'h7);
		chk(4'h2, 2'h0, 13'h0178);
		checked++;
		if ({trap_lvl, trap_syn} !== {PSW_EL2, PSW_SYN_TRAP}) begin
			bad_count++;
			$display("unexpected at %0t ns: trap level or syndrome", $time);
		end
		step(PSW_SEL_AINT, 4'h1, 3'h5);
		chk(4'h8, 2'h0, 13'h017c);
		// Outside level one the trap enables must not stop the write.
		@(posedge i_clock);
		i_exc_level <= PSW_EL2;
		step(PSW_SEL_AINT, 4'h1, 3'h7);
		chk(4'h8, 2'h0, 13'h017c);
		@(posedge i_clock);
		i_exc_level <= PSW_EL1;
		step(PSW_SEL_AINT, 4'h0, 3'h7);
		chk(4'h8, 2'h0, 13'h0178);
		step(PSW_SEL_SMCTL, 4'h7, 3'h0);
		chk(4'h1, 2'h1, 13'h0178);
		step(PSW_SEL_SMCTL, 4'h7, 3'h1);
		chk(4'h8, 2'h1, 13'h017b);
		@(posedge i_clock);
		i_nrst <= 1'b0;
		#1;
		chk(4'h0, 2'h0, 13'h1e80);
		@(posedge i_clock);
		i_nrst <= 1'b1;
		step(PSW_SEL_MCLR, 4'hf, 3'h1);
		chk(4'h8, 2'h0, 13'h0080);
		report_and_stop();
	end
endmodule
